/* hdl/mode_irq_defs.svh */
// constants for the mode map and interrupt vectoring block
`ifndef MODE_IRQ_DEFS_SVH
`define MODE_IRQ_DEFS_SVH
// ==================================================
// apb register offsets
`define A_MODE     12'h000
`define A_CTRL     12'h004
`define A_EN       12'h008
`define A_STAT     12'h00c
`define MASK_RST   1'h1
`define EN_RST     5'h00
// ==================================================
// operating modes
`define M_TEST     3'h0
`define M_MRR      3'h1
`define M_MR2      3'h2
`define M_MR3      3'h3
`define M_UNDEF    3'h4
`define M_NONMULTIPLEXED_BUS     3'h5
`define M_MPD      3'h6
`define M_SINGLE   3'h7
// ==================================================
// address map
`define REG_LO     16'h0000
`define REG_HI     16'hd000
`define IOS_PAGE   8'h01
`define ROM_NIB    4'hf
`define SB_SLICE   3'h2
`define P3_DDR     5'h04
`define P4_DDR     5'h05
`define P3_DAT     5'h06
`define P4_DAT     5'h07
`define P3_CSR     5'h0f
`define VEC_NORM   16'hfff0
`define VEC_TEST   16'hbff0
// ==================================================
// vector slots, offset from the vector base in words
`define VI_RST     3'h7
`define VI_NMI     3'h6
`define VI_SWI     3'h5
`define VI_EXTERNAL_MASKABLE_REQUEST    3'h4
`define VI_ICF     3'h3
`define VI_OCF     3'h2
`define VI_TOF     3'h1
`define VI_SCI     3'h0
`define PUSH_LAST  3'h6
`endif

/* hdl/mode_irq_pkg.sv */
// types for the mode map and interrupt vectoring block
package mode_irq_pkg;
  typedef struct packed {
    logic ext;
    logic is3;
    logic icf;
    logic ocf;
    logic tof;
    logic sci;
  } irq_src_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_PUSH = 2'h1,
    S_VHI  = 2'h3,
    S_VLO  = 2'h2
  } state_t;
endpackage : mode_irq_pkg

/* hdl/mode_map_irq.sv */
// mode latch, address map decode and interrupt vectoring
// Summary of operation
// R1 - latched mode levels select modes 0-3 and 5-7 as listed
// R2 - mode 4 must not be used; its behaviour is undefined
// R3 - lowest 32 addresses decode to the internal register block
// R4 - mode 3 moves RAM and registers to D000-D0FF
// R5 - modes 0, 2, 3: port 3 and 4 addresses go external
// R6 - modes 1, 5, 6: port 3 addresses go external
// R7 - partial decode: port 4 drives address only where direction set
// R8 - mode 5: port 3/4 locations get no external select
// R9 - nonmaskable request always taken at the instruction end
// R10 - maskable requests gated by mask flag and own enable; the external request ext has no enable bit, mask flag only
// R11 - timer and serial share line two; external and strobe line one
// R12 - line one is serviced before line two
// R13 - nonmaskable request waits after reset until stack pointer load
// R14 - normal vectors at FFF0-FFFF, high byte even
// R15 - mode 0 vectors at BFF0-BFFF in the same order
// R16 - line two: capture, compare, overflow, serial by priority
// R17 - push registers, set mask, fetch vector, resume
// R18 - standby RAM at 40-5F, or D040-D05F in mode 3
// R19 - external memory enabled only while bus clock high
// R20 - reset held three bus cycles, mode set up two before; the bench holds reset for three clk cycles only
// R21 - bus clock is the input clock divided by four
// R22 - mode pins caught at reset release, readable as top bits
// R23 - from mode 0 only, writes switch to mode 5, 6 or 7
// R24 - mode 5 select strobe only for addresses 0100-01FF
// R25 - mode fixed until reset; decode uses the latched mode
// R26 - vector high byte from even address first, then low
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "mode_irq_defs.svh"
module mode_map_irq (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   mode_pin2,
  input  wire logic                   mode_pin1,
  input  wire logic                   mode_pin0,
  input  wire logic                   cpu_valid,
  input  wire logic [15:0]            cpu_addr,
  input  wire logic [7:0]             p4_ddr,
  input  wire mode_irq_pkg::irq_src_t irq_src,
  input  wire logic                   nmi_n,
  input  wire logic                   swi_req,
  input  wire logic                   instr_end,
  input  wire logic                   sp_load,
  input  wire logic                   mem_ack,
  input  wire logic [7:0]             mem_rdata,
  output logic                        e_clk,
  output logic                        reg_sel,
  output logic                        ram_sel,
  output logic                        standby_sel,
  output logic                        rom_sel,
  output logic                        ext_sel,
  output logic                        io_window_select,
  output logic                        multiplexed_bus,
  output logic                        nonmultiplexed_bus,
  output logic      [7:0]             port4_addr_oe,
  output logic                        mem_req,
  output logic      [15:0]            mem_addr,
  output logic                        stack_push,
  output logic      [2:0]             push_item,
  output logic                        pc_load,
  output logic      [15:0]            new_pc,
  output logic      [2:0]             mode_out,
  output logic                        mask_flag
);
  // ==================================================
  // state
  logic [1:0]            ediv_q;
  logic                  rst_seen_q;
  logic                  cap_q;
  logic                  mode_latch_bit2;
  logic                  mode_latch_bit1;
  logic                  mode_latch_bit0;
  logic [2:0]            mode_q;
  logic                  mask_q;
  logic [4:0]            en_q;
  logic                  nmi_d1_q;
  logic                  nmi_pend_q;
  logic                  nmi_arm_q;
  mode_irq_pkg::state_t  state_q;
  mode_irq_pkg::state_t  state_d;
  logic [2:0]            vec_idx_q;
  logic [2:0]            sel_idx;
  logic                  take;
  logic [7:0]            vhi_q;
  logic [15:0]           vbase;
  logic                  acc;
  logic                  wr_mode_ok;

  assign mode_q = {mode_latch_bit2, mode_latch_bit1, mode_latch_bit0};
  assign acc    = psel & penable & pready;

  // ==================================================
  // bus clock divider
  always_ff @(posedge clk) begin
    if (reset) begin
      ediv_q <= 2'h0;
      e_clk  <= 1'h0;
    end else begin
      ediv_q <= ediv_q + 2'h1;                        // [R21]
      e_clk  <= (ediv_q == 2'h1) | (ediv_q == 2'h2);  // [R21]
    end
  end

  // ==================================================
  // mode latch
  assign wr_mode_ok = acc & pwrite & (paddr == `A_MODE)
                    & (mode_q == `M_TEST)
                    & ((pwdata[7:5] == `M_NONMULTIPLEXED_BUS) | (pwdata[7:5] == `M_MPD)
                       | (pwdata[7:5] == `M_SINGLE));

  always_ff @(posedge clk) begin
    if (reset) begin
      rst_seen_q <= 1'h1;
      cap_q      <= 1'h0;
      {mode_latch_bit2, mode_latch_bit1, mode_latch_bit0} <= `M_SINGLE;
    end else begin
      rst_seen_q <= 1'h0;
      cap_q      <= rst_seen_q;
      if (rst_seen_q) begin
        {mode_latch_bit2, mode_latch_bit1, mode_latch_bit0}
          <= {mode_pin2, mode_pin1, mode_pin0};       // [R22] [R1]
      end else if (wr_mode_ok) begin
        {mode_latch_bit2, mode_latch_bit1, mode_latch_bit0}
          <= pwdata[7:5];                             // [R23] [R25]
      end
    end
  end
  assign mode_out = mode_q;

  // ==================================================
  // address decode, one cycle behind cpu_addr
  logic [15:0] rbase;
  logic        in_reg;
  logic        p3a;
  logic        p4a;
  logic        p3x;
  logic        p4x;
  logic        reg_hit;
  logic        ram_hit;
  logic        rom_hit;
  logic        ios_hit;
  logic        pd_mode;

  assign rbase   = (mode_q == `M_MR3) ? `REG_HI : `REG_LO;  // [R4]
  assign in_reg  = cpu_addr[15:5] == rbase[15:5];           // [R3]
  assign p3a     = in_reg & ((cpu_addr[4:0] == `P3_DDR)
                 | (cpu_addr[4:0] == `P3_DAT)
                 | (cpu_addr[4:0] == `P3_CSR));
  assign p4a     = in_reg & ((cpu_addr[4:0] == `P4_DDR)
                 | (cpu_addr[4:0] == `P4_DAT));
  assign p4x     = (mode_q == `M_TEST) | (mode_q == `M_MR2)
                 | (mode_q == `M_MR3);                      // [R5]
  assign pd_mode = (mode_q == `M_MRR) | (mode_q == `M_NONMULTIPLEXED_BUS)
                 | (mode_q == `M_MPD);
  assign p3x     = p4x | pd_mode;                           // [R5] [R6]
  assign reg_hit = in_reg & ~(p3a & p3x) & ~(p4a & p4x);    // [R3]
  assign ram_hit = (cpu_addr[15:8] == rbase[15:8])
                 & (cpu_addr[7:6] != 2'h0);                 // [R4]
  assign rom_hit = (cpu_addr[15:12] == `ROM_NIB)
                 & (pd_mode | (mode_q == `M_SINGLE));
  assign ios_hit = (mode_q == `M_NONMULTIPLEXED_BUS)
                 & (cpu_addr[15:8] == `IOS_PAGE);           // [R24]

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_sel          <= 1'h0;
      ram_sel          <= 1'h0;
      standby_sel      <= 1'h0;
      rom_sel          <= 1'h0;
      ext_sel          <= 1'h0;
      io_window_select <= 1'h0;
    end else begin
      reg_sel          <= cpu_valid & reg_hit;
      ram_sel          <= cpu_valid & ram_hit;
      standby_sel      <= cpu_valid & ram_hit
                        & (cpu_addr[7:5] == `SB_SLICE);     // [R18]
      rom_sel          <= cpu_valid & rom_hit;
      io_window_select <= cpu_valid & ios_hit;              // [R24]
      if (mode_q == `M_SINGLE) begin
        ext_sel <= 1'h0;
      end else if (mode_q == `M_NONMULTIPLEXED_BUS) begin
        ext_sel <= cpu_valid & ios_hit;                     // [R8]
      end else begin
        ext_sel <= cpu_valid & ~reg_hit & ~ram_hit & ~rom_hit;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      multiplexed_bus    <= 1'h0;
      nonmultiplexed_bus <= 1'h0;
      port4_addr_oe      <= 8'h00;
    end else begin
      multiplexed_bus    <= p4x | (mode_q == `M_MRR) | (mode_q == `M_MPD);
      nonmultiplexed_bus <= mode_q == `M_NONMULTIPLEXED_BUS;
      if (pd_mode) begin
        port4_addr_oe <= p4_ddr;                            // [R7]
      end else if (p4x) begin
        port4_addr_oe <= 8'hff;
      end else begin
        port4_addr_oe <= 8'h00;
      end
    end
  end

  // ==================================================
  // request capture and arbitration
  logic line1;
  logic line2;
  logic mnmi;

  assign line1 = irq_src.ext | (irq_src.is3 & en_q[4]);     // [R11]
  assign line2 = (irq_src.icf & en_q[3]) | (irq_src.ocf & en_q[2])
               | (irq_src.tof & en_q[1]) | (irq_src.sci & en_q[0]);
  assign mnmi  = nmi_pend_q & nmi_arm_q;                    // [R13]
  assign take  = (state_q == mode_irq_pkg::S_IDLE) & instr_end
               & (mnmi | swi_req | (~mask_q & (line1 | line2)));

  always_comb begin
    if (mnmi) begin
      sel_idx = `VI_NMI;                                    // [R9]
    end else if (swi_req) begin
      sel_idx = `VI_SWI;
    end else if (line1) begin
      sel_idx = `VI_EXTERNAL_MASKABLE_REQUEST;                                   // [R12]
    end else if (irq_src.icf & en_q[3]) begin
      sel_idx = `VI_ICF;                                    // [R16]
    end else if (irq_src.ocf & en_q[2]) begin
      sel_idx = `VI_OCF;
    end else if (irq_src.tof & en_q[1]) begin
      sel_idx = `VI_TOF;
    end else begin
      sel_idx = `VI_SCI;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nmi_d1_q   <= 1'h1;
      nmi_pend_q <= 1'h0;
      nmi_arm_q  <= 1'h0;
    end else begin
      nmi_d1_q   <= nmi_n;
      nmi_arm_q  <= nmi_arm_q | sp_load;                    // [R13]
      nmi_pend_q <= (nmi_d1_q & ~nmi_n)
                  | (nmi_pend_q & ~(take & mnmi));          // [R9]
    end
  end

  // ==================================================
  // interrupt sequencer
  assign vbase = (mode_q == `M_TEST) ? `VEC_TEST : `VEC_NORM;  // [R15]

  always_comb begin
    state_d = state_q;
    case (state_q)
      mode_irq_pkg::S_IDLE: begin
        if (cap_q) begin
          state_d = mode_irq_pkg::S_VHI;
        end else if (take) begin
          state_d = mode_irq_pkg::S_PUSH;                   // [R17]
        end
      end
      mode_irq_pkg::S_PUSH: begin
        if (mem_ack & (push_item == `PUSH_LAST)) begin
          state_d = mode_irq_pkg::S_VHI;
        end
      end
      mode_irq_pkg::S_VHI: begin
        if (mem_ack) begin
          state_d = mode_irq_pkg::S_VLO;                    // [R26]
        end
      end
      mode_irq_pkg::S_VLO: begin
        if (mem_ack) begin
          state_d = mode_irq_pkg::S_IDLE;
        end
      end
      default: state_d = mode_irq_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q   <= mode_irq_pkg::S_IDLE;
      vec_idx_q <= `VI_RST;
      vhi_q     <= 8'h00;
      push_item <= 3'h0;
    end else begin
      state_q <= state_d;
      if (cap_q) begin
        vec_idx_q <= `VI_RST;
      end else if (take) begin
        vec_idx_q <= sel_idx;
      end
      if (take) begin
        push_item <= 3'h0;
      end else if (mem_ack & (state_q == mode_irq_pkg::S_PUSH)) begin
        push_item <= push_item + 3'h1;                      // [R17]
      end
      if (mem_ack & (state_q == mode_irq_pkg::S_VHI)) begin
        vhi_q <= mem_rdata;                                 // [R26]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_req    <= 1'h0;
      mem_addr   <= 16'h0000;
      stack_push <= 1'h0;
      pc_load    <= 1'h0;
      new_pc     <= 16'h0000;
    end else begin
      mem_req    <= state_d != mode_irq_pkg::S_IDLE;
      stack_push <= state_d == mode_irq_pkg::S_PUSH;
      pc_load    <= (state_q == mode_irq_pkg::S_VLO) & mem_ack;
      if (state_d == mode_irq_pkg::S_VHI) begin
        mem_addr <= vbase | {12'h000, (cap_q ? `VI_RST : vec_idx_q),
                             1'h0};                         // [R14] [R15]
      end else if (state_d == mode_irq_pkg::S_VLO) begin
        mem_addr <= vbase | {12'h000, vec_idx_q, 1'h1};     // [R26]
      end
      if ((state_q == mode_irq_pkg::S_VLO) & mem_ack) begin
        new_pc <= {vhi_q, mem_rdata};                       // [R26]
      end
    end
  end

  // ==================================================
  // apb slave: one wait state, answer at the second access cycle
  logic hit;
  assign hit = (paddr == `A_MODE) | (paddr == `A_CTRL)
             | (paddr == `A_EN) | (paddr == `A_STAT);

  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      case (paddr)
        `A_MODE: prdata <= {24'h00_0000, mode_q, 5'h00};   // [R22]
        `A_CTRL: prdata <= {31'h0000_0000, mask_q};
        `A_EN:   prdata <= {27'h000_0000, en_q};
        `A_STAT: prdata <= {20'h0_0000, state_q, nmi_arm_q, nmi_pend_q,
                            line1, line2, vec_idx_q, 3'h0};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= `MASK_RST;
      en_q   <= `EN_RST;
    end else begin
      if ((state_q == mode_irq_pkg::S_PUSH) & (state_d != state_q)) begin
        mask_q <= 1'h1;                                     // [R17]
      end else if (acc & pwrite & (paddr == `A_CTRL)) begin
        mask_q <= pwdata[0];                                // [R10]
      end
      if (acc & pwrite & (paddr == `A_EN)) begin
        en_q <= pwdata[4:0];
      end
    end
  end
  assign mask_flag = mask_q;

  // ==================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_e_period: assert property (                          // [R21]
    $rose(e_clk) |-> ##4 $rose(e_clk)
  ) else $error("bus clock period is not four clocks");

  chk_mode_hold: assert property (                         // [R25]
    !rst_seen_q && !wr_mode_ok |=> $stable(mode_q)
  ) else $error("latched mode changed without cause");

  chk_mode_exit: assert property (                         // [R23]
    wr_mode_ok |=> mode_q >= `M_NONMULTIPLEXED_BUS ##1 $stable(mode_q)
  ) else $error("mode 0 exit did not reach mode 5-7");

  chk_ios_window: assert property (                        // [R24] [R8]
    io_window_select |-> $past(cpu_addr[15:8]) == `IOS_PAGE && ext_sel
  ) else $error("io select outside its page");

  chk_nmi_wait: assert property (                          // [R13]
    !nmi_arm_q && nmi_pend_q |=> nmi_pend_q
  ) else $error("nonmaskable request dropped before arming");

  chk_mask_gate: assert property (                         // [R10]
    take && sel_idx <= `VI_EXTERNAL_MASKABLE_REQUEST |-> !mask_q
  ) else $error("maskable request taken while masked");

  chk_line_order: assert property (                        // [R12]
    take && !mnmi && !swi_req && line1 |=> vec_idx_q == `VI_EXTERNAL_MASKABLE_REQUEST
  ) else $error("line one not serviced first");

  chk_vec_order: assert property (                         // [R26] [R14]
    state_q == mode_irq_pkg::S_VHI && mem_ack
      |=> mem_addr == ($past(mem_addr) | 16'h0001)
      && mem_addr[15:4] == vbase[15:4]
  ) else $error("vector low byte not after high byte");

  chk_push_mask: assert property (                         // [R17]
    state_q == mode_irq_pkg::S_PUSH && mem_ack && push_item == `PUSH_LAST
      |=> state_q == mode_irq_pkg::S_VHI && mask_q
  ) else $error("mask not set after stacking");

endmodule : mode_map_irq

/* sim/ext_mem_model.sv */
// external memory model answering the sequencer's bus steps
`timescale 1ns/1ns
// ==================================================
// answers each step after a chosen delay, only while e is high
module ext_mem_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  input  wire logic        e_clk,
  input  wire logic [1:0]  slow,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  int wait_q;
  always @(posedge clk) begin
    if (reset) begin
      mem_ack   <= 1'b0;
      wait_q    <= 0;
      mem_rdata <= 8'h5a;
    end else if (!mem_req || mem_ack) begin
      mem_ack   <= 1'b0;
      wait_q    <= 0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_q >= slow && e_clk) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8];
    end else begin
      wait_q    <= wait_q + 1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : ext_mem_model

/* sim/tb_mode_map_irq.sv */
// self-checking bench for the mode map and interrupt vectoring block
`timescale 1ns/1ns
`include "mode_irq_defs.svh"
// ==================================================
// bench top
module tb_mode_map_irq;
  logic                   clk, reset, psel, penable, pwrite, err;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic                   pready, pslverr, cpu_valid, nmi_n, swi_req;
  logic                   instr_end, sp_load, mem_ack, e_clk, reg_sel;
  logic                   ram_sel, standby_sel, rom_sel, ext_sel;
  logic                   io_window_select, multiplexed_bus;
  logic                   nonmultiplexed_bus, mem_req, stack_push;
  logic                   pc_load, mask_flag, mode_pin2, mode_pin1;
  logic                   mode_pin0;
  logic [15:0]            cpu_addr, mem_addr, new_pc, base;
  logic [7:0]             p4_ddr, mem_rdata, port4_addr_oe;
  logic [2:0]             push_item, mode_out;
  logic [1:0]             slow;
  mode_irq_pkg::irq_src_t irq_src;
  int                     errors, n_tests, seed, pushes, m;
  logic [5:0]             srcs [6] = '{6'h29, 6'h0f, 6'h07, 6'h03,
                                       6'h01, 6'h11};
  logic [2:0]             slots [6] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4};
  mode_map_irq DUT (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mode_pin2, .mode_pin1,
    .mode_pin0, .cpu_valid, .cpu_addr, .p4_ddr, .irq_src, .nmi_n,
    .swi_req, .instr_end, .sp_load, .mem_ack, .mem_rdata, .e_clk,
    .reg_sel, .ram_sel, .standby_sel, .rom_sel, .ext_sel,
    .io_window_select, .multiplexed_bus, .nonmultiplexed_bus,
    .port4_addr_oe, .mem_req, .mem_addr, .stack_push, .push_item,
    .pc_load, .new_pc, .mode_out, .mask_flag);
  ext_mem_model partner (.clk, .reset, .mem_req, .mem_addr, .e_clk,
    .slow, .mem_ack, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==================================================
  // shared tasks
  function automatic logic [7:0] vb(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : vb
  task tally_and_finish;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      chk("apb timeout", 1, 0);
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task settle;
    @(posedge clk);
    #1;
  endtask : settle
  task dec(input logic [15:0] a);
    @(posedge clk);
    cpu_valid <= 1'b1;
    cpu_addr  <= a;
    settle;
  endtask : dec
  task pulse_end;
    @(posedge clk);
    instr_end <= 1'b1;
    @(posedge clk);
    instr_end <= 1'b0;
  endtask : pulse_end
  task quiet;
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk);
      if (mem_req === 1'b1) seen = 1'b1;
    end
    chk("idle mem_req", 0, seen);
  endtask : quiet
  task wait_pc(input logic [15:0] a);
    int k;
    pushes = 0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (stack_push === 1'b1 && mem_ack === 1'b1) begin
        chk("push_item", pushes, push_item);
        pushes++;
      end
    end while (pc_load !== 1'b1 && k < 200);
    if (k >= 200) begin
      chk("vector timeout", 1, 0);
      tally_and_finish;
    end
    chk("new_pc", {vb(a), vb(a + 16'h0001)}, new_pc);
  endtask : wait_pc
  task serve(input logic [2:0] slot);
    pulse_end;
    wait_pc(16'hfff0 + {12'h000, slot, 1'b0});
    chk("pushes", 7, pushes);
    chk("mask after", 1, mask_flag);
  endtask : serve
  task do_reset(input logic [2:0] md);
    @(posedge clk);
    {mode_pin2, mode_pin1, mode_pin0} <= md;
    p4_ddr <= 8'($random(seed));
    slow   <= 2'($random(seed));
    reset  <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    {mode_pin2, mode_pin1, mode_pin0} <= ~md;
    wait_pc((md == 3'h0) ? 16'hbffe : 16'hfffe);
    chk("reset pushes", 0, pushes);
  endtask : do_reset
  // ==================================================
  // main sequence
  initial begin
    seed = 94;
    errors = 0;
    n_tests = 0;
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {cpu_valid, cpu_addr, p4_ddr, slow} = 27'h0;
    {nmi_n, swi_req, instr_end, sp_load} = 4'h8;
    {mode_pin2, mode_pin1, mode_pin0} = 3'h7;
    irq_src = '0;
    for (m = 0; m < 8; m++) begin
      if (m == 4) continue;
      do_reset(m[2:0]);
      base = (m == 3) ? 16'hd000 : 16'h0000;
      chk("mode_out", m, mode_out);
      apb(1'b0, `A_MODE, 32'h0000_0000);
      chk("mode read", m, rd[7:5]);
      chk("nonmux", m == 5, nonmultiplexed_bus);
      chk("mux", m inside {0, 1, 2, 3, 6}, multiplexed_bus);
      chk("p4 oe", (m inside {1, 5, 6}) ? p4_ddr
        : ((m inside {0, 2, 3}) ? 8'hff : 8'h00), port4_addr_oe);
      dec(base + 16'h0002);
      chk("reg low", 1, reg_sel);
      dec(base + 16'h0006);
      chk("p3 reg", !(m inside {0, 1, 2, 3, 5, 6}), reg_sel);
      chk("p3 ext", m inside {0, 1, 2, 3, 6}, ext_sel);
      dec(base + 16'h0007);
      chk("p4 reg", !(m inside {0, 2, 3}), reg_sel);
      dec(base + 16'h0040);
      chk("standby", 1, standby_sel);
      dec(base + 16'h0060);
      chk("standby off", 0, standby_sel);
      dec(16'h0150);
      chk("io window", m == 5, io_window_select);
      chk("io ext", m != 7, ext_sel);
      dec(16'h0250);
      chk("io outside", 0, io_window_select);
      dec(base + 16'h0080);
      chk("ram", 1, ram_sel);
      dec(16'hf100);
      chk("rom", m inside {1, 5, 6, 7}, rom_sel);
      chk("rom ext", m inside {0, 2, 3}, ext_sel);
      if (m == 0) begin
        apb(1'b1, `A_MODE, 32'h0000_0080);
        settle;
        chk("mode 4 refused", 0, mode_out);
        apb(1'b1, `A_MODE, 32'h0000_00c0);
        settle;
        chk("mode 6 entered", 6, mode_out);
      end
    end
    apb(1'b1, `A_MODE, 32'h0000_0000);
    settle;
    chk("mode kept", 7, mode_out);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    chk("mask reset", 1, mask_flag);
    @(posedge clk);
    nmi_n <= 1'b0;
    repeat (2) @(posedge clk);
    nmi_n <= 1'b1;
    pulse_end;
    quiet;
    sp_load <= 1'b1;
    @(posedge clk);
    sp_load <= 1'b0;
    serve(3'h6);
    irq_src <= mode_irq_pkg::irq_src_t'(6'h20);
    pulse_end;
    quiet;
    irq_src <= mode_irq_pkg::irq_src_t'(6'h08);
    apb(1'b1, `A_EN, 32'h0000_0000);
    apb(1'b1, `A_CTRL, 32'h0000_0000);
    pulse_end;
    quiet;
    apb(1'b1, `A_EN, 32'h0000_001f);
    for (m = 0; m < 6; m++) begin
      irq_src <= mode_irq_pkg::irq_src_t'(srcs[m]);
      apb(1'b1, `A_CTRL, 32'h0000_0000);
      serve(slots[m]);
    end
    irq_src <= '0;
    swi_req <= 1'b1;
    serve(3'h5);
    swi_req <= 1'b0;
    tally_and_finish;
  end
endmodule : tb_mode_map_irq
